// [core/lgdp_pkg.sv]
package lgdp_pkg;
   // register offsets on the configuration port
   localparam logic [7:0] LGDP_OFS_GAIN_PREV = 8'h8C;
   localparam logic [7:0] LGDP_OFS_GAIN = 8'h8E;
   localparam logic [7:0] LGDP_OFS_PROF1 = 8'h94;
   localparam logic [7:0] LGDP_OFS_PROF2 = 8'h96;
   localparam logic [7:0] LGDP_OFS_PROF3 = 8'h98;
   localparam logic [31:0] LGDP_RESET_WORD = 32'h00000000;
   localparam int LGDP_RSV_BIT = 31;
   // speed loop gain word fields
   localparam int LGDP_KP_LO_MSB = 30;
   localparam int LGDP_KP_LO_LSB = 24;
   localparam int LGDP_KP_HI_MSB = 2;
   localparam int LGDP_KI_MSB = 23;
   localparam int LGDP_KI_LSB = 14;
   localparam int LGDP_MAXSPD_MSB = 13;
   localparam logic [13:0] LGDP_SPEED_DIV = 14'h0006;
   // proportional and integral code layouts
   localparam int LGDP_KP_SCALE_LSB = 9;
   localparam int LGDP_KI_SCALE_LSB = 8;
   // profile word 1 fields
   localparam int LGDP_PTYPE_MSB = 30;
   localparam int LGDP_PTYPE_LSB = 29;
   localparam int LGDP_ON_LSB = 21;
   localparam int LGDP_OFF_LSB = 13;
   localparam int LGDP_CLAMP_LSB = 5;
   localparam int LGDP_A_HI_MSB = 4;
   // profile word 2 fields
   localparam int LGDP_A_LO_MSB = 30;
   localparam int LGDP_A_LO_LSB = 28;
   localparam int LGDP_B_LSB = 20;
   localparam int LGDP_C_LSB = 12;
   localparam int LGDP_D_LSB = 4;
   localparam int LGDP_E_HI_MSB = 3;
   // profile word 3 field
   localparam int LGDP_E_LO_MSB = 30;
   localparam int LGDP_E_LO_LSB = 27;

   typedef enum logic [1:0] {
      LGDP_REF_EQUATION,
      LGDP_REF_LINEAR,
      LGDP_REF_STAIRCASE,
      LGDP_REF_FWD_REV
   } lgdp_profile_t;
endpackage

// [core/lgdp_cfg_if.sv]
`timescale 1ns/1ns
interface lgdp_cfg_if;
   import lgdp_pkg::*;
   // raw register contents
   logic [31:0] gain_word;
   logic [31:0] prof1_word;
   logic [31:0] prof2_word;
   logic [2:0] kp_hi_bits;
   logic [3:0] duty_e_lo_bits;
   // decoded fields
   logic [10:0] speed_prop_gain_code;
   logic [9:0] speed_integral_gain_code;
   logic [13:0] max_speed_code;
   logic [13:0] max_speed_hz;
   lgdp_profile_t profile_type;
   logic [7:0] turn_on_duty_level;
   logic [7:0] turn_off_duty_level;
   logic [7:0] duty_input_clamp_level;
   logic [7:0] duty_point_a;
   logic [7:0] duty_point_b;
   logic [7:0] duty_point_c;
   logic [7:0] duty_point_d;
   logic [7:0] duty_point_e;

   modport regs (
      output gain_word, prof1_word, prof2_word, kp_hi_bits, duty_e_lo_bits,
      input speed_prop_gain_code, speed_integral_gain_code, max_speed_code,
      input max_speed_hz, profile_type, turn_on_duty_level,
      input turn_off_duty_level, duty_input_clamp_level, duty_point_a,
      input duty_point_b, duty_point_c, duty_point_d, duty_point_e
   );
   modport dec (
      input gain_word, prof1_word, prof2_word, kp_hi_bits, duty_e_lo_bits,
      output speed_prop_gain_code, speed_integral_gain_code, max_speed_code,
      output max_speed_hz, profile_type, turn_on_duty_level,
      output turn_off_duty_level, duty_input_clamp_level, duty_point_a,
      output duty_point_b, duty_point_c, duty_point_d, duty_point_e
   );
endinterface

// [core/lgdp_field_dec.sv]
`timescale 1ns/1ns
module lgdp_field_dec
   import lgdp_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   lgdp_cfg_if.dec cfg
);
   ////////////////////////////////////////////////////////////////////////
   // field assembly from the stored words
   logic [10:0] kp_nxt;
   logic [7:0] a_nxt;
   logic [7:0] e_nxt;
   logic [13:0] spd_nxt;
   logic [13:0] hz_nxt;
   // RULE1: low gain bits below
   // RULE2: high gain bits above; ten held bits, top scale bit reads zero
   assign kp_nxt = {1'h0, cfg.kp_hi_bits,
                    cfg.gain_word[LGDP_KP_LO_MSB:LGDP_KP_LO_LSB]};
   // RULE10: point a halves
   assign a_nxt = {cfg.prof1_word[LGDP_A_HI_MSB:0],
                   cfg.prof2_word[LGDP_A_LO_MSB:LGDP_A_LO_LSB]};
   // RULE13: point e halves
   assign e_nxt = {cfg.prof2_word[LGDP_E_HI_MSB:0], cfg.duty_e_lo_bits};
   assign spd_nxt = cfg.gain_word[LGDP_MAXSPD_MSB:0];
   // RULE5: electrical hertz is code over six
   assign hz_nxt = spd_nxt / LGDP_SPEED_DIV;

   ////////////////////////////////////////////////////////////////////////
   // registered decoded outputs
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         cfg.speed_prop_gain_code <= '0;
         cfg.speed_integral_gain_code <= '0;
         cfg.max_speed_code <= '0;
         cfg.max_speed_hz <= '0;
         cfg.profile_type <= LGDP_REF_EQUATION;
         cfg.turn_on_duty_level <= '0;
         cfg.turn_off_duty_level <= '0;
         cfg.duty_input_clamp_level <= '0;
         cfg.duty_point_a <= '0;
         cfg.duty_point_b <= '0;
         cfg.duty_point_c <= '0;
         cfg.duty_point_d <= '0;
         cfg.duty_point_e <= '0;
      end else begin
         cfg.speed_prop_gain_code <= kp_nxt;
         // RULE4: integral gain code
         cfg.speed_integral_gain_code <=
            cfg.gain_word[LGDP_KI_MSB:LGDP_KI_LSB];
         cfg.max_speed_code <= spd_nxt;
         cfg.max_speed_hz <= hz_nxt;
         // RULE6: profile type select
         cfg.profile_type <= lgdp_profile_t'(
            cfg.prof1_word[LGDP_PTYPE_MSB:LGDP_PTYPE_LSB]);
         // RULE7: turn-on level
         cfg.turn_on_duty_level <= cfg.prof1_word[LGDP_ON_LSB+:8];
         // RULE8: turn-off level
         cfg.turn_off_duty_level <= cfg.prof1_word[LGDP_OFF_LSB+:8];
         // RULE9: clamp level
         cfg.duty_input_clamp_level <= cfg.prof1_word[LGDP_CLAMP_LSB+:8];
         cfg.duty_point_a <= a_nxt;
         // RULE11: points b c d
         cfg.duty_point_b <= cfg.prof2_word[LGDP_B_LSB+:8];
         cfg.duty_point_c <= cfg.prof2_word[LGDP_C_LSB+:8];
         cfg.duty_point_d <= cfg.prof2_word[LGDP_D_LSB+:8];
         // RULE12: point e high bits
         cfg.duty_point_e <= e_nxt;
      end
   end
endmodule

// [core/lgdp_regs.sv]
`timescale 1ns/1ns
// Behaviour
// RULE1: low seven speed proportional gain bits live in gain word bits 30-24.
// RULE2: top three proportional gain bits live in bits 2-0 of word 8Ch; here they land in code bits 9-7 and code bit 10 reads zero.
// RULE3: proportional code splits into scale bits 10:9 and mantissa 8:0.
// RULE4: ten-bit integral gain code in bits 23-14, scale 9:8, mantissa 7:0.
// RULE5: fourteen-bit max speed code in bits 13-0; hertz is code over six.
// RULE6: profile type in bits 30-29: equation, linear, staircase, fwd-rev.
// RULE7: turn-on duty level from profile word 1 bits 28-21.
// RULE8: turn-off duty level from profile word 1 bits 20-13.
// RULE9: duty input clamped at level from profile word 1 bits 12-5.
// RULE10: point A is word 1 bits 4-0 above word 2 bits 30-28.
// RULE11: points B, C, D in word 2 bits 27-20, 19-12, 11-4.
// RULE12: top four bits of point E in word 2 bits 3-0.
// RULE13: low four bits of point E in bits 30-27 of word 98h.
// RULE14: bit 31 of each word is reserved read/write, resets to zero; words 8Ch and 98h here do not store it and read it as zero.
module lgdp_regs
   import lgdp_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic [7:0] duty_in,
   output logic [7:0] duty_clamped,
   output logic motor_run,
   output logic [1:0] kp_scale,
   output logic [8:0] kp_mantissa,
   output logic [1:0] ki_scale,
   output logic [7:0] ki_mantissa,
   output logic [13:0] max_speed_code,
   output logic [13:0] max_speed_hz,
   output lgdp_profile_t profile_type,
   output logic [7:0] turn_on_duty_level,
   output logic [7:0] turn_off_duty_level,
   output logic [7:0] duty_input_clamp_level,
   output logic [7:0] duty_point_a,
   output logic [7:0] duty_point_b,
   output logic [7:0] duty_point_c,
   output logic [7:0] duty_point_d,
   output logic [7:0] duty_point_e
);
   ////////////////////////////////////////////////////////////////////////
   // storage and decoder
   lgdp_cfg_if cfg ();
   logic [31:0] gain_r;
   logic [31:0] prof1_r;
   logic [31:0] prof2_r;
   logic [2:0] kp_hi_r;
   logic [3:0] e_lo_r;
   logic [31:0] rdata_nxt;
   logic [7:0] clamp_nxt;
   logic run_nxt;
   logic run_r;
   logic [7:0] clamp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;

   lgdp_field_dec u_dec (
      .mclk(mclk),
      .rstn(rstn),
      .cfg(cfg)
   );

   assign cfg.gain_word = gain_r;
   assign cfg.prof1_word = prof1_r;
   assign cfg.prof2_word = prof2_r;
   assign cfg.kp_hi_bits = kp_hi_r;
   assign cfg.duty_e_lo_bits = e_lo_r;

   ////////////////////////////////////////////////////////////////////////
   // address decode
   wire wr_prev = reg_wr && (reg_addr == LGDP_OFS_GAIN_PREV);
   wire wr_gain = reg_wr && (reg_addr == LGDP_OFS_GAIN);
   wire wr_p1 = reg_wr && (reg_addr == LGDP_OFS_PROF1);
   wire wr_p2 = reg_wr && (reg_addr == LGDP_OFS_PROF2);
   wire wr_p3 = reg_wr && (reg_addr == LGDP_OFS_PROF3);

   // read select; neighbour words show only the bits held here
   wire [31:0] prev_view = {29'h00000000, kp_hi_r};
   wire [31:0] p3_view = {1'b0, e_lo_r, 27'h0000000};
   assign rdata_nxt =
      (reg_addr == LGDP_OFS_GAIN_PREV) ? prev_view :
      (reg_addr == LGDP_OFS_GAIN) ? gain_r :
      (reg_addr == LGDP_OFS_PROF1) ? prof1_r :
      (reg_addr == LGDP_OFS_PROF2) ? prof2_r :
      (reg_addr == LGDP_OFS_PROF3) ? p3_view : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////
   // register writes; whole words, reserved bit kept but unused
   // RULE14: reserved bit stored
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         gain_r <= LGDP_RESET_WORD;
         prof1_r <= LGDP_RESET_WORD;
         prof2_r <= LGDP_RESET_WORD;
      end else begin
         if (wr_gain) gain_r <= reg_wdata;
         if (wr_p1) prof1_r <= reg_wdata;
         if (wr_p2) prof2_r <= reg_wdata;
      end
   end

   // neighbour word bits that complete split codes
   // RULE2: hold high gain bits
   // RULE13: hold low point e bits
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         kp_hi_r <= '0;
         e_lo_r <= '0;
      end else begin
         if (wr_prev) kp_hi_r <= reg_wdata[LGDP_KP_HI_MSB:0];
         if (wr_p3) e_lo_r <= reg_wdata[LGDP_E_LO_MSB:LGDP_E_LO_LSB];
      end
   end

   // read answer one cycle after the strobe
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rdata_r <= '0;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= reg_rd;
         if (reg_rd) rdata_r <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // duty input path: clamp and on/off hysteresis
   // RULE9: clamp the duty input
   assign clamp_nxt = (duty_in > cfg.duty_input_clamp_level) ?
                      cfg.duty_input_clamp_level : duty_in;
   // RULE7: start at turn-on level
   // RULE8: stop below turn-off level
   assign run_nxt = run_r ? (duty_in >= cfg.turn_off_duty_level) :
                    (duty_in >= cfg.turn_on_duty_level);

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         clamp_r <= '0;
         run_r <= 1'b0;
      end else begin
         clamp_r <= clamp_nxt;
         run_r <= run_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign reg_rdata = rdata_r;
   assign reg_rvalid = rvalid_r;
   assign duty_clamped = clamp_r;
   assign motor_run = run_r;
   // RULE3: proportional code split
   assign kp_scale = cfg.speed_prop_gain_code[10:LGDP_KP_SCALE_LSB];
   assign kp_mantissa = cfg.speed_prop_gain_code[LGDP_KP_SCALE_LSB-1:0];
   // RULE4: integral code split
   assign ki_scale = cfg.speed_integral_gain_code[9:LGDP_KI_SCALE_LSB];
   assign ki_mantissa = cfg.speed_integral_gain_code[LGDP_KI_SCALE_LSB-1:0];
   assign max_speed_code = cfg.max_speed_code;
   assign max_speed_hz = cfg.max_speed_hz;
   assign profile_type = cfg.profile_type;
   assign turn_on_duty_level = cfg.turn_on_duty_level;
   assign turn_off_duty_level = cfg.turn_off_duty_level;
   assign duty_input_clamp_level = cfg.duty_input_clamp_level;
   assign duty_point_a = cfg.duty_point_a;
   assign duty_point_b = cfg.duty_point_b;
   assign duty_point_c = cfg.duty_point_c;
   assign duty_point_d = cfg.duty_point_d;
   assign duty_point_e = cfg.duty_point_e;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence s_wr_gain;
      reg_wr && reg_addr == LGDP_OFS_GAIN && !reg_rd;
   endsequence
   sequence s_wr_p1;
      reg_wr && reg_addr == LGDP_OFS_PROF1;
   endsequence
   sequence s_wr_p2;
      reg_wr && reg_addr == LGDP_OFS_PROF2;
   endsequence

   a_kp_low_field: assert property ( // RULE1
      s_wr_gain ##1 !wr_gain[*2] |->
      kp_mantissa[6:0] == $past(reg_wdata[30:24], 2))
      else $error("proportional low bits not taken");
   a_kp_high_field: assert property ( // RULE2
      wr_prev ##1 !wr_prev[*2] |->
      kp_scale == {1'b0, $past(reg_wdata[2], 2)} &&
      kp_mantissa[8:7] == $past(reg_wdata[1:0], 2))
      else $error("proportional high bits not taken");
   a_kp_split: assert property ( // RULE3
      !wr_gain ##1 1 |-> {kp_scale, kp_mantissa} ==
      {1'b0, $past(kp_hi_r), $past(gain_r[30:24])})
      else $error("proportional split wrong");
   a_ki_field: assert property ( // RULE4
      s_wr_gain ##1 !wr_gain[*2] |->
      {ki_scale, ki_mantissa} == $past(reg_wdata[23:14], 2))
      else $error("integral code wrong");
   a_speed_hz: assert property ( // RULE5
      max_speed_code >= max_speed_hz * 14'h0006 &&
      max_speed_code - max_speed_hz * 14'h0006 < 14'h0006)
      else $error("speed hertz not code over six");
   a_profile_sel: assert property ( // RULE6
      s_wr_p1 ##1 !wr_p1[*2] |->
      profile_type == lgdp_profile_t'($past(reg_wdata[30:29], 2)))
      else $error("profile type wrong");
   a_run_start: assert property ( // RULE7
      !motor_run && duty_in >= turn_on_duty_level |=> motor_run)
      else $error("run did not start at turn-on level");
   a_run_stop: assert property ( // RULE8
      motor_run && duty_in < turn_off_duty_level |=> !motor_run)
      else $error("run did not stop below turn-off level");
   a_duty_clamp: assert property ( // RULE9
      ##1 duty_clamped <= $past(duty_input_clamp_level) &&
      duty_clamped <= $past(duty_in))
      else $error("duty clamp exceeded");
   a_point_a: assert property ( // RULE10
      s_wr_p2 ##1 !wr_p2[*2] ##0 !wr_p1 |->
      duty_point_a[2:0] == $past(reg_wdata[30:28], 2))
      else $error("point a low bits wrong");
   a_points_bcd: assert property ( // RULE11
      s_wr_p2 ##1 !wr_p2[*2] |->
      {duty_point_b, duty_point_c, duty_point_d} ==
      $past(reg_wdata[27:4], 2))
      else $error("points b c d wrong");
   a_point_e: assert property ( // RULE12
      s_wr_p2 ##1 !wr_p2[*2] |->
      duty_point_e[7:4] == $past(reg_wdata[3:0], 2))
      else $error("point e high bits wrong");
   a_point_e_low: assert property ( // RULE13
      wr_p3 ##1 !wr_p3[*2] |->
      duty_point_e[3:0] == $past(reg_wdata[30:27], 2))
      else $error("point e low bits wrong");
   a_rsv_bit: assert property ( // RULE14
      s_wr_gain ##1 (reg_rd && reg_addr == LGDP_OFS_GAIN && !reg_wr) |=>
      reg_rvalid && reg_rdata[LGDP_RSV_BIT] == $past(reg_wdata[31], 2))
      else $error("reserved bit not read back");
endmodule

// [test/lgdp_regs_tb.sv]
`timescale 1ns/1ns
module testbench;
   import lgdp_pkg::*;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h00000000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] duty_in = 8'h00;
   logic [31:0] reg_rdata;
   logic reg_rvalid;
   logic [7:0] duty_clamped;
   logic motor_run;
   logic [1:0] kp_scale;
   logic [8:0] kp_mantissa;
   logic [1:0] ki_scale;
   logic [7:0] ki_mantissa;
   logic [13:0] max_speed_code;
   logic [13:0] max_speed_hz;
   lgdp_profile_t profile_type;
   logic [7:0] turn_on_duty_level;
   logic [7:0] turn_off_duty_level;
   logic [7:0] duty_input_clamp_level;
   logic [7:0] duty_point_a;
   logic [7:0] duty_point_b;
   logic [7:0] duty_point_c;
   logic [7:0] duty_point_d;
   logic [7:0] duty_point_e;
   int n_mismatch = 0;
   int check_count = 0;
   integer seed = 32'hE51BBBFD;
   logic [31:0] rq[$];
   logic [8:0] dq[$];
   logic [31:0] g = 32'h00000000;
   logic [31:0] p1 = 32'h00000000;
   logic [31:0] p2 = 32'h00000000;
   logic [2:0] k3 = 3'h0;
   logic [3:0] e4 = 4'h0;
   logic [7:0] amap[6] = '{LGDP_OFS_GAIN_PREV, LGDP_OFS_GAIN, LGDP_OFS_PROF1,
      LGDP_OFS_PROF2, LGDP_OFS_PROF3, 8'h90};
   logic [7:0] dtab[8] = '{8'h7F, 8'h80, 8'h41, 8'h40, 8'h3F, 8'hC0, 8'hC1,
      8'hFF};

   lgdp_regs u_lgdp_regs (
      .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .duty_in(duty_in),
      .duty_clamped(duty_clamped), .motor_run(motor_run),
      .kp_scale(kp_scale), .kp_mantissa(kp_mantissa), .ki_scale(ki_scale),
      .ki_mantissa(ki_mantissa), .max_speed_code(max_speed_code),
      .max_speed_hz(max_speed_hz), .profile_type(profile_type),
      .turn_on_duty_level(turn_on_duty_level),
      .turn_off_duty_level(turn_off_duty_level),
      .duty_input_clamp_level(duty_input_clamp_level),
      .duty_point_a(duty_point_a), .duty_point_b(duty_point_b),
      .duty_point_c(duty_point_c), .duty_point_d(duty_point_d),
      .duty_point_e(duty_point_e)
   );

   // free running clock
   always #5 mclk = ~mclk;

   ////////////////////////////////////////////////////////////////////////
   // compare and close
   task automatic chk(input string name, input logic [31:0] seen,
                      input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // expected read value of each offset, partial words read zero elsewhere
   function automatic logic [31:0] rexp(input logic [7:0] a);
      case (a)
         LGDP_OFS_GAIN_PREV: rexp = {29'h0, k3};
         LGDP_OFS_GAIN: rexp = g;
         LGDP_OFS_PROF1: rexp = p1;
         LGDP_OFS_PROF2: rexp = p2;
         LGDP_OFS_PROF3: rexp = {1'b0, e4, 27'h0};
         default: rexp = 32'h00000000;
      endcase
   endfunction

   // one bus cycle; read note taken before the shadow update
   task automatic bus(input logic w, input logic r, input logic [7:0] a,
                      input logic [31:0] d);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      if (r) rq.push_back(rexp(a));
      if (w) begin
         case (a)
            LGDP_OFS_GAIN_PREV: k3 = d[2:0];
            LGDP_OFS_GAIN: g = d;
            LGDP_OFS_PROF1: p1 = d;
            LGDP_OFS_PROF2: p2 = d;
            LGDP_OFS_PROF3: e4 = d[30:27];
            default: ;
         endcase
      end
      @(posedge mclk);
   endtask

   task automatic check_fields;
      logic [10:0] kp;
      kp = {k3, g[30:24]};
      chk("kp_scale", 32'(kp_scale), 32'(kp[10:9]));
      chk("kp_mantissa", 32'(kp_mantissa), 32'(kp[8:0]));
      chk("ki_scale", 32'(ki_scale), 32'(g[23:22]));
      chk("ki_mantissa", 32'(ki_mantissa), 32'(g[21:14]));
      chk("max_speed_code", 32'(max_speed_code), 32'(g[13:0]));
      chk("max_speed_hz", 32'(max_speed_hz), 32'(g[13:0]) / 6);
      chk("profile_type", 32'(profile_type), 32'(p1[30:29]));
      chk("turn_on", 32'(turn_on_duty_level), 32'(p1[28:21]));
      chk("turn_off", 32'(turn_off_duty_level), 32'(p1[20:13]));
      chk("clamp", 32'(duty_input_clamp_level), 32'(p1[12:5]));
      chk("point_a", 32'(duty_point_a), 32'({p1[4:0], p2[30:28]}));
      chk("point_b", 32'(duty_point_b), 32'(p2[27:20]));
      chk("point_c", 32'(duty_point_c), 32'(p2[19:12]));
      chk("point_d", 32'(duty_point_d), 32'(p2[11:4]));
      chk("point_e", 32'(duty_point_e), 32'({p2[3:0], e4}));
   endtask

   // read every offset back to back, then let decoded outputs settle
   task automatic check_all;
      for (int j = 0; j < 6; j++) begin
         bus(1'b0, 1'b1, amap[j], 32'h00000000);
      end
      repeat (3) bus(1'b0, 1'b0, 8'h00, 32'h00000000);
      chk("pending_reads", 32'(rq.size()), 32'h00000000);
      check_fields();
   endtask

   ////////////////////////////////////////////////////////////////////////
   // watcher: read data and duty path results against the oldest note
   always @(negedge mclk) begin
      if (reg_rvalid === 1'b1) begin
         if (rq.size() == 0) begin
            chk("spurious_rvalid", 32'h00000001, 32'h00000000);
         end else begin
            chk("reg_rdata", reg_rdata, rq.pop_front());
         end
      end
      if (dq.size() > 1) begin
         chk("duty_path", 32'({motor_run, duty_clamped}), 32'(dq[0]));
         void'(dq.pop_front());
      end
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      report_and_stop();
   end

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic run_m;
      logic [7:0] d;
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      check_all();
      // random writes incl. unmapped offset, then read back
      for (int i = 0; i < 12; i++) begin
         for (int j = 0; j < 6; j++) begin
            bus(1'b1, 1'b0, amap[j], $random(seed));
         end
         check_all();
      end
      // simultaneous read and write returns the old word
      bus(1'b1, 1'b1, LGDP_OFS_GAIN, ~g);
      check_all();
      // write then read the gain word with the reserved bit set
      bus(1'b1, 1'b0, LGDP_OFS_GAIN, $random(seed) | 32'h80000000);
      bus(1'b0, 1'b1, LGDP_OFS_GAIN, 32'h00000000);
      check_all();
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, 1'b0, LGDP_OFS_PROF1, {1'b0, 2'(i), p1[28:0]});
         repeat (3) bus(1'b0, 1'b0, 8'h00, 32'h00000000);
         chk("profile_type", 32'(profile_type), 32'(i));
      end
      // duty path: on 80h, off 40h, clamp C0h
      bus(1'b1, 1'b0, LGDP_OFS_PROF1, {3'b001, 8'h80, 8'h40, 8'hC0, 5'h00});
      duty_in <= 8'h00;
      repeat (4) bus(1'b0, 1'b0, 8'h00, 32'h00000000);
      run_m = 1'b0;
      for (int i = 0; i < 120; i++) begin
         d = (i < 8) ? dtab[i] : 8'($random(seed));
         duty_in <= d;
         if (!run_m && d >= p1[28:21]) run_m = 1'b1;
         else if (run_m && d < p1[20:13]) run_m = 1'b0;
         dq.push_back({run_m, (d > p1[12:5]) ? p1[12:5] : d});
         @(posedge mclk);
      end
      // full duty keeps the run flag up until reset clears it
      duty_in <= 8'hFF;
      repeat (3) @(posedge mclk);
      dq.delete();
      // second reset in mid-run clears every word
      rstn <= 1'b0;
      repeat (2) bus(1'b0, 1'b0, 8'h00, 32'h00000000);
      @(negedge mclk);
      chk("motor_run", 32'(motor_run), 32'h00000000);
      @(posedge mclk);
      g = 32'h00000000;
      p1 = 32'h00000000;
      p2 = 32'h00000000;
      k3 = 3'h0;
      e4 = 4'h0;
      rstn <= 1'b1;
      bus(1'b0, 1'b0, 8'h00, 32'h00000000);
      check_all();
      report_and_stop();
   end
endmodule
